// ==== dv/flash_program_erase_control_tb.sv ====
// self-checking bench for the flash program/erase sequencer
module flash_program_erase_control_tb;
  import fpe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] P = 32'h5a5a0000;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  fpe_op_type           req_op = FPE_OP_NONE;
  logic [ADDR_BITS-1:0] req_addr = '0;
  logic [LEN_BITS-1:0]  req_len = '0;
  logic [WORD_BITS-1:0] wr_data;
  logic [WORD_BITS-1:0] rd_data;
  logic                 wr_ready;
  logic                 busy;
  logic                 done;
  logic                 err;
  int                   fails = 0;
  int                   total_checks = 0;
  int                   lat;
  int                   nrdy;
  int                   nbusy;

  fpe_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
    .wr_data(wr_data), .wr_ready(wr_ready), .busy(busy), .done(done),
    .err(err), .rd_data(rd_data));
  fpe_fw_model fw (.clk_sys(clk_sys), .rst(rst), .start(req_valid),
    .wr_ready(wr_ready), .wr_data(wr_data));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one request; counts cycles and write strobes until done or err
  task automatic run(input fpe_op_type op, input logic [13:0] a,
                     input logic [5:0] n);
    // idle edge first, so back-to-back calls never retoggle req_valid
    @(posedge clk_sys);
    #1 req_op = op;
    req_addr = a;
    req_len = n;
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    // cycle after the request edge is cycle 1; sample it too
    lat = 1;
    nrdy = (wr_ready === 1'b1) ? 1 : 0;
    nbusy = (busy === 1'b1) ? 1 : 0;
    while (!(done === 1'b1 || err === 1'b1)) begin
      @(posedge clk_sys);
      #1 lat++;
      if (wr_ready === 1'b1) nrdy++;
      if (busy === 1'b1) nbusy++;
      if (lat > 300) begin
        fails++;
        conclude();
      end
    end
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    run(FPE_OP_READ, a, 6'h00);
    chk(lat, 2);
    chk(done, 1'b1);
    chk(nbusy, 32'h1);
    chk(rd_data, exp);
  endtask

  task automatic prog(input logic [13:0] a, input logic [5:0] n);
    run(FPE_OP_PROG, a, n);
    chk(err, 1'b0);
    chk(lat, n + 1);
    chk(nrdy, n);
    chk(nbusy, n);
  endtask

  task automatic bad(input fpe_op_type op, input logic [13:0] a,
                     input logic [5:0] n);
    run(op, a, n);
    chk(err, 1'b1);
    chk(lat, 1);
    chk(nrdy, 0);
    chk(nbusy, 32'h0);
  endtask

  task automatic t_program;
    prog(14'h0800, 6'h02);
    rd(14'h0800, P);
    rd(14'h0804, P + 1);
    prog(14'h0c00, 6'h20);
    rd(14'h0c7c, P + 31);
    prog(14'h3ffc, 6'h01);
    rd(14'h3ffc, P);
    $display("test program done");
  endtask

  task automatic t_refuse;
    bad(FPE_OP_PROG, 14'h0802, 6'h01);
    bad(FPE_OP_PROG, 14'h0800, 6'h00);
    bad(FPE_OP_PROG, 14'h0800, 6'h21);
    bad(FPE_OP_PROG, 14'h087c, 6'h02);
    bad(FPE_OP_ERASE, 14'h07fc, 6'h00);
    bad(FPE_OP_NONE, 14'h0800, 6'h00);
    rd(14'h0800, P);
    $display("test refuse done");
  endtask

  task automatic t_erase;
    run(FPE_OP_ERASE, 14'h0910, 6'h00);
    chk(lat, 129);
    chk(nbusy, 32'h80);
    rd(14'h0804, ERASED_WORD);
    rd(14'h09fc, ERASED_WORD);
    rd(14'h0c7c, P + 31);
    $display("test erase done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_program();
    t_refuse();
    t_erase();
    conclude();
  end
endmodule

// ==== dv/fpe_fw_model.sv ====
// firmware-side data source feeding program words
module fpe_fw_model
  import fpe_pkg::*;
(
  input  wire logic                 clk_sys,  // system clock
  input  wire logic                 rst,      // sync reset
  input  wire logic                 start,    // new request
  input  wire logic                 wr_ready, // word taken this cycle
  output logic [WORD_BITS-1:0]      wr_data   // word k is base + k
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]           idx_q;
  logic [5:0]           idx_d;
  logic [WORD_BITS-1:0] pat;
  always_comb begin
    idx_d = start ? 6'h00 : idx_q + {5'h00, wr_ready};
  end
  always_ff @(posedge clk_sys) begin
    idx_q <= rst ? 6'h00 : idx_d;
  end
  assign pat = 32'h5a5a0000 + {26'h0, idx_q};
  // inverted when not taken, so a stray sample shows up
  assign wr_data = wr_ready ? pat : ~pat;
endmodule

// ==== hdl/fpe_ctrl.sv ====
// flash array with program, erase and read sequencing
module fpe_ctrl
  import fpe_pkg::*;
(
  input  wire logic                  clk_sys,    // system clock
  input  wire logic                  rst,        // sync reset, high
  input  wire logic                  req_valid,  // request strobe
  input  wire fpe_op_type            req_op,     // operation
  input  wire logic [ADDR_BITS-1:0]  req_addr,   // byte address
  input  wire logic [LEN_BITS-1:0]   req_len,    // words to program
  input  wire logic [WORD_BITS-1:0]  wr_data,    // program data
  output logic                       wr_ready,   // take wr_data now
  output logic                       busy,       // operation running
  output logic                       done,       // completion pulse
  output logic                       err,        // refusal pulse
  output logic [WORD_BITS-1:0]       rd_data     // read result
);
  logic [WORD_BITS-1:0] mem [WORDS];

  fpe_state_type          st_q, st_d;
  logic [WADDR_BITS-1:0]  wa_q, wa_d;
  logic [LEN_BITS-1:0]    cnt_q, cnt_d;
  logic                   wr_ready_q, wr_ready_d;
  logic                   busy_q, busy_d;
  logic                   done_q, done_d;
  logic                   err_q, err_d;
  logic [WORD_BITS-1:0]   rd_q, rd_d;
  logic                   mem_we;
  logic [WORD_BITS-1:0]   mem_wd;

  logic [WADDR_BITS-1:0]  req_wa;
  logic [6:0]             row_end;
  logic                   prog_ok, erase_ok;

  assign req_wa  = req_addr[ADDR_BITS-1:2];
  // word offset within row plus length must not pass row end
  assign row_end = {2'h0, req_wa[4:0]} + {1'h0, req_len};
  assign prog_ok = (req_addr[1:0] == 2'h0)
                 && (req_len != 6'h00)
                 && (req_len <= MAX_LEN)
                 && (row_end <= 7'(ROW_WORDS));
  // erase address is rounded to its page; only page index matters
  assign erase_ok = (req_wa[WADDR_BITS-1:PAGE_SHIFT] >= PROT_PAGES);

  always_comb begin
    st_d       = st_q;
    wa_d       = wa_q;
    cnt_d      = cnt_q;
    wr_ready_d = 1'b0;
    busy_d     = busy_q;
    done_d     = 1'b0;
    err_d      = 1'b0;
    rd_d       = rd_q;
    mem_we     = 1'b0;
    mem_wd     = wr_data;
    case (st_q)
      FPE_IDLE: begin
        if (req_valid) begin
          case (req_op)
            FPE_OP_READ: begin
              wa_d   = req_wa;
              st_d   = FPE_READ;
              busy_d = 1'b1;
            end
            FPE_OP_PROG: begin
              if (prog_ok) begin
                wa_d       = req_wa;
                cnt_d      = req_len;
                wr_ready_d = 1'b1;
                st_d       = FPE_PROG;
                busy_d     = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            FPE_OP_ERASE: begin
              if (erase_ok) begin
                wa_d   = {req_wa[WADDR_BITS-1:PAGE_SHIFT], 7'h00};
                cnt_d  = 6'h00;
                st_d   = FPE_ERASE;
                busy_d = 1'b1;
              end else begin
                err_d = 1'b1;
              end
            end
            default: err_d = 1'b1;
          endcase
        end
      end
      FPE_PROG: begin
        // one word per cycle; data taken while wr_ready is high
        mem_we = 1'b1;
        wa_d   = wa_q + 12'h001;
        cnt_d  = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          st_d   = FPE_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          wr_ready_d = 1'b1;
        end
      end
      FPE_ERASE: begin
        // flash programs bits low only, so erased state is all ones
        mem_we = 1'b1;
        mem_wd = ERASED_WORD;
        wa_d   = wa_q + 12'h001;
        if (wa_q[PAGE_SHIFT-1:0] == 7'h7f) begin
          st_d   = FPE_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
      FPE_READ: begin
        rd_d   = mem[wa_q];
        st_d   = FPE_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      default: begin
        st_d   = FPE_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q       <= FPE_IDLE;
      wa_q       <= '0;
      cnt_q      <= '0;
      wr_ready_q <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      rd_q       <= '0;
    end else begin
      st_q       <= st_d;
      wa_q       <= wa_d;
      cnt_q      <= cnt_d;
      wr_ready_q <= wr_ready_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      err_q      <= err_d;
      rd_q       <= rd_d;
    end
  end

  // array contents are not reset, as real flash keeps them
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[wa_q] <= mem_wd;
    end
  end

  assign wr_ready = wr_ready_q;
  assign busy     = busy_q;
  assign done     = done_q;
  assign err      = err_q;
  assign rd_data  = rd_q;

  // helpers for assertions
  logic [7:0] erase_cycles;
  always_ff @(posedge clk_sys) begin
    if (rst || st_q != FPE_ERASE) begin
      erase_cycles <= 8'h00;
    end else begin
      erase_cycles <= erase_cycles + 8'h01;
    end
  end

  misalign_refused_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_IDLE && req_valid && req_op == FPE_OP_PROG
     && req_addr[1:0] != 2'h0) |=> (err && st_q == FPE_IDLE))
    else $error("misaligned program not refused");

  prog_too_long_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_IDLE && req_valid && req_op == FPE_OP_PROG
     && req_len > MAX_LEN) |=> err)
    else $error("oversize program not refused");

  row_cross_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_PROG && mem_we) |-> (wa_q[4:0] != 5'h1f || cnt_q == 6'h01))
    else $error("program crossed row boundary");

  erase_page_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_ERASE && $past(st_q) == FPE_IDLE)
      |-> (wa_q[PAGE_SHIFT-1:0] == 7'h00))
    else $error("erase not page aligned");

  erase_length_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_ERASE) |-> (erase_cycles < 8'h80))
    else $error("erase ran past one page");

  protect_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (mem_we && st_q == FPE_ERASE) |-> (wa_q[11:7] >= PROT_PAGES))
    else $error("protected page erased");

  read_done_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == FPE_IDLE && req_valid && req_op == FPE_OP_READ)
      |=> busy ##1 (done && !busy))
    else $error("read did not finish in two cycles");

  refuse_idle_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    err |-> (!busy && !done && st_q == FPE_IDLE))
    else $error("error with operation started");
endmodule

// ==== inc/fpe_pkg.sv ====
// constants and types for the flash program/erase sequencer
package fpe_pkg;
  localparam int          WORD_BITS    = 32;
  localparam int          WORDS        = 4096;
  localparam int          ADDR_BITS    = 14;  // byte address of 16 KB
  localparam int          WADDR_BITS   = 12;
  localparam int          ROW_BYTES    = 128;
  localparam int          ROW_WORDS    = 32;
  localparam int          LEN_BITS     = 6;   // word count 1..32
  localparam int          PAGE_WORDS   = 128; // 4 rows, 512 bytes
  localparam int          PAGE_SHIFT   = 7;   // word address to page index
  localparam logic [31:0] ERASED_WORD  = 32'hffffffff;
  // first unprotected page; pages below hold factory firmware
  localparam logic [4:0]  PROT_PAGES   = 5'h04;
  localparam logic [5:0]  MAX_LEN      = 6'h20;

  typedef enum logic [1:0] {
    FPE_OP_READ,
    FPE_OP_PROG,
    FPE_OP_ERASE,
    FPE_OP_NONE
  } fpe_op_type;

  typedef enum {
    FPE_IDLE,
    FPE_PROG,
    FPE_ERASE,
    FPE_READ
  } fpe_state_type;
endpackage
